// ---- logic/fas_pkg.sv ----
`default_nettype none
package fas_pkg;
    // internal mantissa: bit 58 carry, bit 57 hidden, guard bits below the format lsb
    localparam int FAS_MW = 59;
    localparam int FAS_SGL_LSB = 34;
    localparam int FAS_DBL_LSB = 5;
    localparam logic signed [12:0] FAS_SGL_BIAS = 13'sh7f;
    localparam logic signed [12:0] FAS_DBL_BIAS = 13'sh3ff;
    localparam logic signed [12:0] FAS_SGL_EMIN = -13'sh7e;
    localparam logic signed [12:0] FAS_DBL_EMIN = -13'sh3fe;
    localparam logic signed [12:0] FAS_SGL_EMAX = 13'sh7f;
    localparam logic signed [12:0] FAS_DBL_EMAX = 13'sh3ff;
    // saturation patterns, kept exactly as given
    localparam logic [63:0] FAS_SGL_UNF = 64'h0000_0000_0ff7_ffff;
    localparam logic [63:0] FAS_SGL_OVF = 64'h0000_0000_7f7f_ffff;
    localparam logic [63:0] FAS_DBL_UNF = 64'h0000_ffef_ffff_ffff;
    localparam logic [63:0] FAS_DBL_OVF = 64'h0007_feff_ffff_ffff;
    localparam logic [15:0] FAS_ERR_RANGE = 16'h2013;
    localparam logic [15:0] FAS_RST_CODE = 16'h0000;
    localparam logic [63:0] FAS_RST_DEST = 64'h0;
    typedef enum logic [2:0] {
        FAS_IDLE,
        FAS_ADD,
        FAS_NORM,
        FAS_ROUND,
        FAS_FIN
    } fas_state_t;
endpackage
`default_nettype wire

// ---- logic/fas_sticky_shr.sv ----
`default_nettype none
module fas_sticky_shr #(
    parameter int WIDTH = 59
) (
    // operand and distance
    input wire logic [WIDTH-1:0] value_i,
    input wire logic [12:0] amount_i,
    // shifted value, lost bits folded into bit 0
    output logic [WIDTH-1:0] value_o
);
    // shifts past the width give zero, so every bit lands in the sticky
    wire [WIDTH-1:0] shifted = value_i >> amount_i;
    wire [WIDTH-1:0] kept_mask = {WIDTH{1'b1}} << amount_i;
    wire lost = |(value_i & ~kept_mask);
    assign value_o = {shifted[WIDTH-1:1], shifted[0] | lost};
endmodule
`default_nettype wire

// ---- logic/fas_unit.sv ----
// Summary of operation
// - add: destination gets first plus second
// - subtract: destination gets first minus second
// - zero result turns zero flag on
// - single: saturate to given small/large patterns
// - double: saturate to given small/large patterns
// - bad operand: no write, error flag, code
// - single: two words, higher word upper half
// - double: four words, highest word most significant
`default_nettype none
module fas_unit (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // request from the sequencer
    input wire logic exec_en_i,
    input wire logic edge_mode_i,
    input wire logic op_sub_i,
    input wire logic dbl_i,
    input wire logic [63:0] first_source_operand_i,
    input wire logic [63:0] second_source_operand_i,
    input wire logic err_clear_i,
    // result
    output logic busy_o,
    output logic done_o,
    output logic dest_we_o,
    output logic dest_dbl_o,
    output logic [63:0] dest_o,
    // flags
    output logic zero_result_flag_o,
    output logic operation_error_flag_o,
    output logic [15:0] error_code_register_o
);
    import fas_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // operand decoding; word k of an operand sits at bits 16k+15:16k
    function automatic logic fas_bad(input logic [63:0] w, input logic d);
        fas_bad = d ? &w[62:52] : &w[30:23];
    endfunction

    function automatic logic fas_sgn(input logic [63:0] w, input logic d);
        fas_sgn = d ? w[63] : w[31];
    endfunction

    function automatic logic signed [12:0] fas_exp(input logic [63:0] w, input logic d);
        logic [10:0] be;
        be = d ? w[62:52] : {3'h0, w[30:23]};
        if (be == 11'h0) begin
            fas_exp = d ? FAS_DBL_EMIN : FAS_SGL_EMIN;
        end else begin
            fas_exp = $signed({2'b00, be}) - (d ? FAS_DBL_BIAS : FAS_SGL_BIAS);
        end
    endfunction

    function automatic logic [58:0] fas_man(input logic [63:0] w, input logic d);
        if (d) begin
            fas_man = {1'b0, |w[62:52], w[51:0], 5'h0};
        end else begin
            fas_man = {1'b0, |w[30:23], w[22:0], 34'h0};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    fas_state_t st;
    logic en_prev;
    logic dbl;
    logic sub;
    logic [63:0] opa;
    logic [63:0] opb;
    logic rsign;
    logic signed [12:0] e;
    logic [58:0] m;

    // edge mode fires once per rising enable; scan mode fires on every cycle with enable high
    wire fire = exec_en_i && (!edge_mode_i || !en_prev);
    wire take = (st == FAS_IDLE) && fire;
    wire bad_in = fas_bad(first_source_operand_i, dbl_i) || fas_bad(second_source_operand_i, dbl_i);
    wire take_ok = take && !bad_in;
    wire take_bad = take && bad_in;

    // alignment and add/subtract
    wire signed [12:0] ea = fas_exp(opa, dbl);
    wire signed [12:0] eb = fas_exp(opb, dbl);
    wire [58:0] ma = fas_man(opa, dbl);
    wire [58:0] mb = fas_man(opb, dbl);
    wire sa = fas_sgn(opa, dbl);
    wire sb = fas_sgn(opb, dbl) ^ sub;
    wire swap = eb > ea;
    wire [58:0] big_m = swap ? mb : ma;
    wire [58:0] small_m = swap ? ma : mb;
    wire big_s = swap ? sb : sa;
    wire small_s = swap ? sa : sb;
    wire signed [12:0] big_e = swap ? eb : ea;
    wire signed [12:0] diff_e = swap ? eb - ea : ea - eb;
    wire [58:0] small_sh;
    wire eff_sub = sa ^ sb;
    wire big_ge = big_m >= small_sh;
    wire [58:0] sum_m = big_m + small_sh;
    wire [58:0] dif_m = big_ge ? big_m - small_sh : small_sh - big_m;
    wire dif_s = big_ge ? big_s : small_s;

    fas_sticky_shr #(.WIDTH(FAS_MW)) u_align (
        .value_i(small_m),
        .amount_i(diff_e),
        .value_o(small_sh)
    );

    // normalisation stops at the format's least exponent to keep subnormals
    wire signed [12:0] emin = dbl ? FAS_DBL_EMIN : FAS_SGL_EMIN;
    wire signed [12:0] emax = dbl ? FAS_DBL_EMAX : FAS_SGL_EMAX;
    wire [58:0] m_dn = {1'b0, m[58:2], m[1] | m[0]};
    wire [58:0] m_up = {m[57:0], 1'b0};

    // truncate toward zero at the format's lsb; a tie keeps the lower code, so results never grow
    wire [58:0] unit = 59'h1 << (dbl ? FAS_DBL_LSB : FAS_SGL_LSB);
    wire [58:0] low_mask = unit - 59'h1;
    wire [58:0] m_rnd = m & ~low_mask;

    // packing and saturation
    wire [58:0] m_f = m[58] ? {1'b0, m[58:1]} : m;
    wire signed [12:0] e_f = m[58] ? e + 13'sh1 : e;
    wire signed [12:0] e_biased = e_f + (dbl ? FAS_DBL_BIAS : FAS_SGL_BIAS);
    wire res_zero = m_f == 59'h0;
    wire res_ovf = e_f > emax;
    wire res_unf = !res_zero && !m_f[57];
    wire [63:0] packed_dbl = {rsign, e_biased[10:0], m_f[56:5]};
    wire [63:0] packed_sgl = {32'h0, rsign, e_biased[7:0], m_f[56:34]};
    wire [63:0] sat_ovf = dbl ? FAS_DBL_OVF : FAS_SGL_OVF;
    wire [63:0] sat_unf = dbl ? FAS_DBL_UNF : FAS_SGL_UNF;
    wire [63:0] result = res_zero ? 64'h0 :
                         res_ovf ? sat_ovf :
                         res_unf ? sat_unf :
                         dbl ? packed_dbl : packed_sgl;

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            st <= FAS_IDLE;
            en_prev <= 1'b0;
            dbl <= 1'b0;
            sub <= 1'b0;
            opa <= 64'h0;
            opb <= 64'h0;
        end else begin
            en_prev <= exec_en_i;
            case (st)
                FAS_IDLE: begin
                    if (take_ok) begin
                        st <= FAS_ADD;
                        dbl <= dbl_i;
                        sub <= op_sub_i;
                        opa <= first_source_operand_i;
                        opb <= second_source_operand_i;
                    end
                end
                FAS_ADD: st <= FAS_NORM;
                FAS_NORM: begin
                    if (m == 59'h0) begin
                        st <= FAS_FIN;
                    end else if (m[58] || m[57] || e <= emin) begin
                        st <= FAS_ROUND;
                    end
                end
                FAS_ROUND: st <= FAS_FIN;
                FAS_FIN: st <= FAS_IDLE;
                default: st <= FAS_IDLE;
            endcase
        end
    end

    // datapath
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            m <= 59'h0;
            e <= 13'sh0;
            rsign <= 1'b0;
        end else if (st == FAS_ADD) begin
            m <= eff_sub ? dif_m : sum_m;
            e <= big_e;
            rsign <= eff_sub ? dif_s : big_s;
        end else if (st == FAS_NORM && m[58]) begin
            m <= m_dn;
            e <= e + 13'sh1;
        end else if (st == FAS_NORM && m != 59'h0 && !m[57] && e > emin) begin
            m <= m_up;
            e <= e - 13'sh1;
        end else if (st == FAS_ROUND) begin
            m <= m_rnd;
        end
    end

    // outputs; an error skips the write and leaves destination untouched
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            dest_we_o <= 1'b0;
            dest_dbl_o <= 1'b0;
            dest_o <= FAS_RST_DEST;
            zero_result_flag_o <= 1'b0;
            operation_error_flag_o <= 1'b0;
            error_code_register_o <= FAS_RST_CODE;
        end else begin
            busy_o <= take_ok || (busy_o && st != FAS_FIN);
            done_o <= take_bad || st == FAS_FIN;
            dest_we_o <= st == FAS_FIN;
            if (st == FAS_FIN) begin
                dest_dbl_o <= dbl;
                dest_o <= result;
                zero_result_flag_o <= res_zero;
            end
            // a new error wins over a clear in the same cycle
            if (take_bad) begin
                operation_error_flag_o <= 1'b1;
                error_code_register_o <= FAS_ERR_RANGE;
            end else if (err_clear_i) begin
                operation_error_flag_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_bad_take;
        take_bad;
    endsequence

    sequence s_self_sub;
        take_ok && op_sub_i && first_source_operand_i == second_source_operand_i;
    endsequence

    sequence s_zero_add;
        take_ok && !op_sub_i && !dbl_i && first_source_operand_i[30:0] == 31'h0 &&
            second_source_operand_i[30:0] == 31'h0;
    endsequence

    a_err_no_write:
    assert property (s_bad_take |=> done_o && !dest_we_o && operation_error_flag_o &&
        error_code_register_o == FAS_ERR_RANGE)
        else $error("bad operand not rejected");

    a_err_dest_held:
    assert property (s_bad_take |=> $stable(dest_o))
        else $error("destination changed on error");

    a_sub_self_zero:
    assert property (s_self_sub |-> ##[3:70] (dest_we_o && zero_result_flag_o && dest_o == 64'h0))
        else $error("x minus x not zero");

    a_add_zero:
    assert property (s_zero_add |-> ##[3:70] (dest_we_o && dest_o[30:0] == 31'h0))
        else $error("zero plus zero not zero");

    a_zero_flag:
    assert property (dest_we_o |-> (zero_result_flag_o == (dest_o == 64'h0)))
        else $error("zero flag disagrees with result");

    a_sgl_no_inf:
    assert property (dest_we_o && !dest_dbl_o |-> dest_o[30:23] != 8'hff)
        else $error("single result not saturated");

    a_dbl_no_inf:
    assert property (dest_we_o && dest_dbl_o && dest_o != FAS_DBL_OVF |-> dest_o[62:52] != 11'h7ff)
        else $error("double result not saturated");

    a_sgl_upper:
    assert property (dest_we_o && !dest_dbl_o |-> dest_o[63:32] == 32'h0)
        else $error("single result upper words not clear");

    a_done_bound:
    assert property (take_ok |=> busy_o ##[2:68] (done_o && dest_we_o && !busy_o))
        else $error("operation did not finish");
endmodule
`default_nettype wire

// ---- testbench/fas_seq_model.sv ----
`default_nettype none
module fas_seq_model (
    // request from the bench
    input wire logic go_i,
    input wire logic dbl_i,
    input wire logic [3:0][15:0] first_words_i,
    input wire logic [3:0][15:0] second_words_i,
    // to the unit
    output logic exec_en_o,
    output logic [63:0] first_source_operand_o,
    output logic [63:0] second_source_operand_o
);
    logic [63:0] first_packed;
    logic [63:0] second_packed;
    ////////////////////////////////////////////////////////////////////////////////
    // single: words 1:0 only; upper half is junk that the unit must ignore
    assign first_packed = dbl_i ? first_words_i : {~first_words_i[1:0], first_words_i[1:0]};
    assign second_packed = dbl_i ? second_words_i : {~second_words_i[1:0], second_words_i[1:0]};
    // outside a request the operands invert, so late sampling shows
    assign first_source_operand_o = go_i ? first_packed : ~first_packed;
    assign second_source_operand_o = go_i ? second_packed : ~second_packed;
    // enable level per instruction, precision alongside
    assign exec_en_o = go_i;
endmodule
`default_nettype wire

// ---- testbench/tb_fas_unit.sv ----
`default_nettype none
module tb_fas_unit;
    timeunit 1ns;
    timeprecision 100ps;
    import fas_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic go = 1'b0;
    logic edge_mode = 1'b1;
    logic op_sub = 1'b0;
    logic dbl = 1'b0;
    logic err_clear = 1'b0;
    logic [3:0][15:0] fw = '0;
    logic [3:0][15:0] sw = '0;
    logic exec_en;
    logic [63:0] first_op;
    logic [63:0] second_op;
    logic busy, done, dest_we, dest_dbl, zero, err_flag;
    logic [63:0] dest;
    logic [15:0] code;
    int fails = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////////////////////
    fas_seq_model i_seq (.go_i(go), .dbl_i(dbl), .first_words_i(fw), .second_words_i(sw),
        .exec_en_o(exec_en), .first_source_operand_o(first_op), .second_source_operand_o(second_op));
    fas_unit i_dut (.clock_i(clock), .reset_n_i(reset_n), .exec_en_i(exec_en), .edge_mode_i(edge_mode),
        .op_sub_i(op_sub), .dbl_i(dbl), .first_source_operand_i(first_op), .second_source_operand_i(second_op),
        .err_clear_i(err_clear), .busy_o(busy), .done_o(done), .dest_we_o(dest_we), .dest_dbl_o(dest_dbl),
        .dest_o(dest), .zero_result_flag_o(zero), .operation_error_flag_o(err_flag), .error_code_register_o(code));
    initial begin
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one request, held for the taking edge only, then a bounded wait for done
    task automatic run_op(input logic sub, input logic d, input logic [63:0] a, input logic [63:0] b);
        int n;
        @(posedge clock);
        #1;
        op_sub = sub;
        dbl = d;
        fw = a;
        sw = b;
        go = 1'b1;
        @(posedge clock);
        #1;
        go = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (done !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic expect_ok(input logic sub, input logic d, input logic [63:0] a, input logic [63:0] b,
        input logic [63:0] exp, input logic z);
        run_op(sub, d, a, b);
        chk("dest_we", 64'(dest_we), 64'h1);
        chk("dest", dest, exp);
        chk("zero", 64'(zero), 64'(z));
        chk("dest_dbl", 64'(dest_dbl), 64'(d));
        chk("busy", 64'(busy), 64'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic sc_add();
        expect_ok(1'b0, 1'b0, 64'h4046b852, 64'h3fb9999a, 64'h4091c28f, 1'b0);
        expect_ok(1'b0, 1'b1, 64'h4008d70a3d70a3d7, 64'h3ff7333333333333, 64'h40123851eb851eb8, 1'b0);
        expect_ok(1'b0, 1'b0, 64'h80000000, 64'h0, 64'h0, 1'b1);
    endtask
    task automatic sc_sub();
        expect_ok(1'b1, 1'b0, 64'h40400000, 64'h3f800000, 64'h40000000, 1'b0);
        expect_ok(1'b1, 1'b0, 64'h3f800000, 64'h3f800000, 64'h0, 1'b1);
        expect_ok(1'b1, 1'b1, 64'h4008000000000000, 64'h3ff0000000000000, 64'h4000000000000000, 1'b0);
        expect_ok(1'b1, 1'b1, 64'h4000000000000000, 64'h4000000000000000, 64'h0, 1'b1);
    endtask
    // largest plus largest, and two close smallest normals giving a subnormal
    task automatic sc_saturate();
        expect_ok(1'b0, 1'b0, 64'h7f7fffff, 64'h7f7fffff, FAS_SGL_OVF, 1'b0);
        expect_ok(1'b1, 1'b0, 64'h00800001, 64'h00800000, FAS_SGL_UNF, 1'b0);
        expect_ok(1'b0, 1'b1, 64'h7fefffffffffffff, 64'h7fefffffffffffff, FAS_DBL_OVF, 1'b0);
        expect_ok(1'b1, 1'b1, 64'h0010000000000001, 64'h0010000000000000, FAS_DBL_UNF, 1'b0);
    endtask
    task automatic sc_reject();
        expect_ok(1'b0, 1'b0, 64'h3f800000, 64'h3f800000, 64'h40000000, 1'b0);
        run_op(1'b0, 1'b0, 64'h7f800000, 64'h3f800000);
        chk("dest_we", 64'(dest_we), 64'h0);
        chk("err_flag", 64'(err_flag), 64'h1);
        chk("code", 64'(code), 64'(FAS_ERR_RANGE));
        chk("busy", 64'(busy), 64'h0);
        run_op(1'b1, 1'b1, 64'h3ff0000000000000, 64'h7ff8000000000000);
        chk("dest_we", 64'(dest_we), 64'h0);
        chk("dest", dest, 64'h40000000);
        chk("dest_dbl", 64'(dest_dbl), 64'h0);
        @(posedge clock);
        #1;
        err_clear = 1'b1;
        @(posedge clock);
        #1;
        chk("err_flag", 64'(err_flag), 64'h0);
        chk("code", 64'(code), 64'(FAS_ERR_RANGE));
        // a rejection in the same cycle as a clear keeps the flag set
        run_op(1'b0, 1'b0, 64'h3f800000, 64'hff800000);
        err_clear = 1'b0;
        chk("err_flag", 64'(err_flag), 64'h1);
        chk("dest", dest, 64'h40000000);
    endtask
    // enable held high: edge mode runs once, scan mode keeps repeating
    task automatic sc_modes(input logic em, input int exp_min, input int exp_max);
        int cnt;
        cnt = 0;
        @(posedge clock);
        #1;
        edge_mode = em;
        dbl = 1'b0;
        op_sub = 1'b0;
        fw = 64'h3f800000;
        sw = 64'h3f800000;
        go = 1'b1;
        repeat (30) begin
            @(posedge clock);
            #1;
            if (done === 1'b1) begin
                cnt++;
            end
        end
        go = 1'b0;
        chk("op count in range", 64'(cnt >= exp_min && cnt <= exp_max), 64'h1);
        chk("dest", dest, 64'h40000000);
        repeat (10) @(posedge clock);
        #1;
        edge_mode = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clock);
        #1;
        reset_n = 1'b1;
        sc_add();
        sc_sub();
        sc_saturate();
        sc_reject();
        sc_modes(1'b1, 1, 1);
        sc_modes(1'b0, 2, 30);
        give_verdict();
    end
endmodule
`default_nettype wire
